// ==== hw/uos_out_sel.sv ====
// Purpose: function select and polarity for one user output pin
// Assumes: caller registers the result
// Notes: isSecond picks the pin-specific half of the split codes
`timescale 1ns/10ps
`default_nettype none
module uos_out_sel import uos_pkg::*; #(
  parameter bit IS_SECOND = 1'b0
) (
  input wire logic [3:0] sel,
  input wire logic invert,
  input wire uos_chan_sig_t sig,
  output logic pinNxt
);

  logic routed;
  logic crcGated;
  logic splitData;
  logic splitRail;

  // crc error indication is held low while sync is lost
  assign crcGated = sig.rxCrcErrorPulse & ~sig.rxLossSync;
  assign splitData = IS_SECOND ? sig.txNrzData : sig.rxDataPreStore;
  assign splitRail = IS_SECOND ? sig.txPosRail : sig.txNegRail;

  always_comb begin
    case (sel)
      SEL_RX_CLOCK: routed = sig.rxRecoveredClock;
      SEL_LOSS_SYNC: routed = sig.rxLossSync;
      SEL_LOSS_CARRIER: routed = sig.rxLossCarrier;
      SEL_REMOTE_ALARM: routed = sig.rxRemoteAlarm;
      SEL_ALL_ONES: routed = sig.rxAllOnes;
      SEL_SLIP: routed = sig.rxSlipPulse;
      SEL_CRC_ERROR: routed = crcGated;
      SEL_LOSS_TX_CLOCK: routed = sig.txLossClock;
      SEL_FRAME_SYNC: routed = sig.rxRecoveredFrameSync;
      SEL_PRBS_ERROR: routed = sig.rxPrbsErrorPulse;
      SEL_NRZ_DATA: routed = splitData;
      SEL_CRC4_MF_SYNC: routed = sig.rxCrc4MfSync;
      SEL_CAS_MF_SYNC: routed = sig.rxCasMfSync;
      SEL_TX_CURRENT_LIMIT: routed = sig.txCurrentLimit;
      SEL_TX_RAILS: routed = splitRail;
      default: routed = 1'b0;
    endcase
  end

  // static mode drives the inversion bit itself, other modes invert the routed signal
  assign pinNxt = (sel == SEL_STATIC) ? invert : (routed ^ invert);

endmodule // uos_out_sel
`default_nettype wire

// ==== hw/uos_pkg.sv ====
// Purpose: shared constants and carrier types for the user output select block
// Assumes: one 8-bit control register pair per transceiver, four transceivers
// Notes: register offsets and field positions live here only
package uos_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_OUTPUT_A_CONTROL = 8'h1a;
  localparam logic [7:0] ADDR_OUTPUT_B_CONTROL = 8'h1b;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int OUT_INVERT_BIT = 4;
  localparam int CMI_LINE_EN_BIT = 5;
  localparam int CMI_INPUT_INVERT_BIT = 6;
  localparam int TTL_RAIL_INPUT_EN_BIT = 7;
  localparam int NRZ_INPUT_EN_BIT = 7;

  // ****************************************
  // function select codes
  // ****************************************
  localparam logic [3:0] SEL_STATIC = 4'h0;
  localparam logic [3:0] SEL_RX_CLOCK = 4'h1;
  localparam logic [3:0] SEL_LOSS_SYNC = 4'h2;
  localparam logic [3:0] SEL_LOSS_CARRIER = 4'h3;
  localparam logic [3:0] SEL_REMOTE_ALARM = 4'h4;
  localparam logic [3:0] SEL_ALL_ONES = 4'h5;
  localparam logic [3:0] SEL_SLIP = 4'h6;
  localparam logic [3:0] SEL_CRC_ERROR = 4'h7;
  localparam logic [3:0] SEL_LOSS_TX_CLOCK = 4'h8;
  localparam logic [3:0] SEL_FRAME_SYNC = 4'h9;
  localparam logic [3:0] SEL_PRBS_ERROR = 4'ha;
  localparam logic [3:0] SEL_NRZ_DATA = 4'hb;
  localparam logic [3:0] SEL_CRC4_MF_SYNC = 4'hc;
  localparam logic [3:0] SEL_CAS_MF_SYNC = 4'hd;
  localparam logic [3:0] SEL_TX_CURRENT_LIMIT = 4'he;
  localparam logic [3:0] SEL_TX_RAILS = 4'hf;

  // internal signals of one transceiver that may be routed to a user output
  typedef struct packed {
    logic rxRecoveredClock;
    logic rxRecoveredFrameSync;
    logic rxCrc4MfSync;
    logic rxCasMfSync;
    logic rxLossSync;
    logic rxLossCarrier;
    logic rxRemoteAlarm;
    logic rxAllOnes;
    logic rxSlipPulse;
    logic rxCrcErrorPulse;
    logic txLossClock;
    logic rxPrbsErrorPulse;
    logic txNrzData;
    logic rxDataPreStore;
    logic txPosRail;
    logic txNegRail;
    logic txCurrentLimit;
  } uos_chan_sig_t;

  // received rail pair after the input front end
  typedef struct packed {
    logic pos;
    logic neg;
    logic valid;
  } uos_rx_rail_t;

endpackage

// ==== hw/uos_top.sv ====
// Purpose: user output select and receive input options for four transceivers
// Assumes: host port is a plain synchronous register port with a channel select
// Notes: every output is registered on the rising edge of mclk
//
// Contract
// - Bit 4 of the first output control register inverts the first user output.
// - Bit 4 of the second output control register inverts the second user output.
// - Select code 0000 drives the pin statically at the level of its inversion bit.
// - Bits 3..0 of each output control register pick the signal routed to its pin.
// - Bit 7 of the first register makes the line inputs take logic-level rail data.
// - In that logic-level rail mode the rails are sampled on the falling mclk edge.
// - Bit 7 of the second register turns tip into NRZ data clocked by ring's falling edge.
// - Bit 5 of the first register enables coded-mark-inversion line operation.
// - Bit 6 of the first register inverts received coded-mark-inversion data.
// - Codes 0001, 1001, 1100, 1101 route recovered clock, frame sync, CRC4 and CAS syncs.
// - Codes 0010, 0011, 0100, 0101, 1000 route the real-time alarm levels.
// - Codes 0110, 0111, 1010 route slip, gated CRC error and PRBS error pulses.
// - Code 1011 splits NRZ tx/rx data and code 1111 splits the encoded tx rails.
`timescale 1ns/10ps
`default_nettype none
module uos_top import uos_pkg::*; #(
  parameter int NUM_CHAN = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] hostChan,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostWr,
  input wire logic hostRd,
  output logic [7:0] hostRdData,
  input wire uos_chan_sig_t [NUM_CHAN-1:0] chanSig,
  input wire logic [NUM_CHAN-1:0] rxLineTip,
  input wire logic [NUM_CHAN-1:0] rxLineRing,
  output logic [NUM_CHAN-1:0] userOutFirst,
  output logic [NUM_CHAN-1:0] userOutSecond,
  output uos_rx_rail_t [NUM_CHAN-1:0] rxRail,
  output logic [NUM_CHAN-1:0] cmiLineEn
);

  // ****************************************
  // host register port decode
  // ****************************************
  logic [7:0] ctrlA_r [NUM_CHAN];
  logic [7:0] ctrlB_r [NUM_CHAN];
  logic hitA;
  logic hitB;
  logic [7:0] rdSel;
  logic [7:0] hostRdData_nxt;

  assign hitA = (hostAddr == ADDR_OUTPUT_A_CONTROL);
  assign hitB = (hostAddr == ADDR_OUTPUT_B_CONTROL);
  // unmapped addresses read back as zero
  assign rdSel = hitA ? ctrlA_r[hostChan] : (hitB ? ctrlB_r[hostChan] : RD_UNMAPPED);
  // read data holds its last value between reads
  assign hostRdData_nxt = hostRd ? rdSel : hostRdData;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hostRdData <= RD_UNMAPPED;
    end else begin
      hostRdData <= hostRdData_nxt;
    end
  end

  // ****************************************
  // per-transceiver logic
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic chanHit;
      logic wrA;
      logic wrB;
      logic [7:0] ctrlA_nxt;
      logic [7:0] ctrlB_nxt;
      logic firstNxt;
      logic secondNxt;
      logic ttlEn;
      logic nrzEn;
      logic cmiEn;
      logic cmiInv;
      logic dataInv;
      logic ttlPos_r;
      logic ttlNeg_r;
      logic ringPrev_r;
      logic ringFall;
      uos_rx_rail_t rail_nxt;
      logic [1:0] ctlSel;

      // ******************************
      // control registers
      // ******************************
      // each channel owns its pair, writes to one channel never touch another
      assign chanHit = (hostChan == 2'(ch));
      assign wrA = hostWr & chanHit & hitA;
      assign wrB = hostWr & chanHit & hitB;
      // reserved bits of the second register are stored as written
      assign ctrlA_nxt = wrA ? hostWrData : ctrlA_r[ch];
      assign ctrlB_nxt = wrB ? hostWrData : ctrlB_r[ch];

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ctrlA_r[ch] <= CTRL_RESET;
          ctrlB_r[ch] <= CTRL_RESET;
        end else begin
          ctrlA_r[ch] <= ctrlA_nxt;
          ctrlB_r[ch] <= ctrlB_nxt;
        end
      end

      // ******************************
      // user output pins
      // ******************************
      uos_out_sel #(
        .IS_SECOND(1'b0)
      ) u_first (
        .sel(ctrlA_r[ch][SEL_MSB:SEL_LSB]),
        .invert(ctrlA_r[ch][OUT_INVERT_BIT]),
        .sig(chanSig[ch]),
        .pinNxt(firstNxt)
      );

      uos_out_sel #(
        .IS_SECOND(1'b1)
      ) u_second (
        .sel(ctrlB_r[ch][SEL_MSB:SEL_LSB]),
        .invert(ctrlB_r[ch][OUT_INVERT_BIT]),
        .sig(chanSig[ch]),
        .pinNxt(secondNxt)
      );

      // registered pins add one mclk of latency to every routed signal
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          userOutFirst[ch] <= 1'b0;
          userOutSecond[ch] <= 1'b0;
        end else begin
          userOutFirst[ch] <= firstNxt;
          userOutSecond[ch] <= secondNxt;
        end
      end

      // ******************************
      // receive input front end
      // ******************************
      assign ttlEn = ctrlA_r[ch][TTL_RAIL_INPUT_EN_BIT];
      assign nrzEn = ctrlB_r[ch][NRZ_INPUT_EN_BIT];
      assign cmiEn = ctrlA_r[ch][CMI_LINE_EN_BIT];
      assign cmiInv = ctrlA_r[ch][CMI_INPUT_INVERT_BIT];
      // inversion only applies while the line is in coded-mark-inversion mode
      assign dataInv = cmiEn & cmiInv;

      // logic-level rails are caught on the falling mclk edge
      always_ff @(negedge mclk) begin
        if (!rst_n) begin
          ttlPos_r <= 1'b0;
          ttlNeg_r <= 1'b0;
        end else begin
          ttlPos_r <= rxLineTip[ch];
          ttlNeg_r <= rxLineRing[ch];
        end
      end

      // ring is the NRZ clock; its falling edge is found against the previous sample
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ringPrev_r <= 1'b0;
        end else begin
          ringPrev_r <= rxLineRing[ch];
        end
      end
      assign ringFall = ringPrev_r & ~rxLineRing[ch];

      // NRZ wins over logic-level rails when both enables are set
      assign ctlSel = {nrzEn, ttlEn};

      always_comb begin
        rail_nxt = rxRail[ch];
        rail_nxt.valid = 1'b1;
        case (ctlSel)
          2'b10, 2'b11: begin
            rail_nxt.valid = ringFall;
            // single data line: the negative rail is idle in this mode
            rail_nxt.neg = 1'b0;
            if (ringFall) begin
              rail_nxt.pos = rxLineTip[ch] ^ dataInv;
            end
          end
          2'b01: begin
            rail_nxt.pos = ttlPos_r ^ dataInv;
            rail_nxt.neg = ttlNeg_r ^ dataInv;
          end
          2'b00: begin
            // normal line mode: the sliced rails arrive on tip and ring
            rail_nxt.pos = rxLineTip[ch] ^ dataInv;
            rail_nxt.neg = rxLineRing[ch] ^ dataInv;
          end
          default: begin
            rail_nxt.pos = 1'b0;
            rail_nxt.neg = 1'b0;
          end
        endcase
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          rxRail[ch] <= '0;
          cmiLineEn[ch] <= 1'b0;
        end else begin
          rxRail[ch] <= rail_nxt;
          cmiLineEn[ch] <= cmiEn;
        end
      end
    end
  endgenerate

endmodule // uos_top
`default_nettype wire

// ==== tb/uos_partner.sv ====
// Purpose: board-side source of serial NRZ data with its own clock on tip and ring
// Assumes: one byte per send request, msb first
// Notes: the clock stands still low between frames
`timescale 1ns/10ps
`default_nettype none
module uos_partner (
  input wire logic mclk,
  input wire logic send,
  input wire logic [7:0] txByte,
  output logic tip,
  output logic ring,
  output logic busy
);
  // ****************************************
  // frame generator
  // ****************************************
  initial begin
    tip = 1'b0;
    ring = 1'b0;
    busy = 1'b0;
  end
  always begin
    wait (send);
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(negedge mclk);
      tip = txByte[i];
      ring = 1'b1;
      repeat (2) @(negedge mclk);
      ring = 1'b0;
      @(negedge mclk);
    end
    @(negedge mclk);
    // released data line shows the inverse so a stale bit cannot pass
    tip = !tip;
    busy = 1'b0;
    wait (!send);
  end
endmodule // uos_partner
`default_nettype wire

// ==== tb/uos_top_monitor.sv ====
// Purpose: port-level checks of the user output select block, channel 0
// Assumes: shadow copies follow host writes to channel 0
// Notes: outputs are one mclk behind their causes
`timescale 1ns/10ps
`default_nettype none
module uos_top_monitor import uos_pkg::*; #(
  parameter int NUM_CHAN = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] hostChan,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [7:0] hostRdData,
  input wire uos_chan_sig_t [NUM_CHAN-1:0] chanSig,
  input wire logic [NUM_CHAN-1:0] rxLineTip,
  input wire logic [NUM_CHAN-1:0] rxLineRing,
  input wire logic [NUM_CHAN-1:0] userOutFirst,
  input wire logic [NUM_CHAN-1:0] userOutSecond,
  input wire uos_rx_rail_t [NUM_CHAN-1:0] rxRail,
  input wire logic [NUM_CHAN-1:0] cmiLineEn
);
  // ****************************************
  // shadow registers and checks
  // ****************************************
  logic [7:0] shA_r;
  logic [7:0] shB_r;
  wire logic wr0 = hostWr && (hostChan == 2'h0);
  // single-bit copies so that every sampled-value call sees a plain signal
  wire logic invA = shA_r[OUT_INVERT_BIT];
  wire logic invB = shB_r[OUT_INVERT_BIT];
  wire logic cmiOn = shA_r[CMI_LINE_EN_BIT];
  wire logic cmiFlip = shA_r[CMI_LINE_EN_BIT] && shA_r[CMI_INPUT_INVERT_BIT];
  wire logic lossSync0 = chanSig[0].rxLossSync;
  wire logic txNrz0 = chanSig[0].txNrzData;
  wire logic tip0 = rxLineTip[0];
  wire logic ring0 = rxLineRing[0];
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shA_r <= CTRL_RESET;
      shB_r <= CTRL_RESET;
    end else begin
      if (wr0 && hostAddr == ADDR_OUTPUT_A_CONTROL) shA_r <= hostWrData;
      if (wr0 && hostAddr == ADDR_OUTPUT_B_CONTROL) shB_r <= hostWrData;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence ringFall;
    shB_r[NRZ_INPUT_EN_BIT] && $past(ring0) && !ring0;
  endsequence
  a_read_back: assert property (hostRd && hostChan == 2'h0 &&
    hostAddr == ADDR_OUTPUT_A_CONTROL |=> hostRdData == $past(shA_r)) else $error("read mismatch");
  a_unmapped_read: assert property (hostRd && hostAddr != ADDR_OUTPUT_A_CONTROL &&
    hostAddr != ADDR_OUTPUT_B_CONTROL |=> hostRdData == RD_UNMAPPED) else $error("unmapped read");
  a_static_level: assert property (shA_r[SEL_MSB:SEL_LSB] == SEL_STATIC
    |=> userOutFirst[0] == $past(invA)) else $error("static level wrong");
  a_route_invert: assert property (shA_r[SEL_MSB:SEL_LSB] == SEL_LOSS_SYNC
    |=> userOutFirst[0] == ($past(lossSync0) ^ $past(invA))) else $error("route wrong");
  a_second_pair: assert property (shB_r[SEL_MSB:SEL_LSB] == SEL_NRZ_DATA
    |=> userOutSecond[0] == ($past(txNrz0) ^ $past(invB))) else $error("pair wrong");
  a_crc_gated: assert property (shA_r[4:0] == {1'b0, SEL_CRC_ERROR} &&
    lossSync0 |=> !userOutFirst[0]) else $error("crc not gated");
  a_cmi_follow: assert property (1'b1 |=> cmiLineEn[0] == $past(cmiOn))
    else $error("cmi enable wrong");
  a_nrz_capture: assert property (ringFall
    |=> rxRail[0].valid && rxRail[0].pos == ($past(tip0) ^ $past(cmiFlip)))
    else $error("nrz capture");
endmodule // uos_top_monitor
bind uos_top uos_top_monitor #(.NUM_CHAN(NUM_CHAN)) uMon (.mclk(mclk), .rst_n(rst_n),
  .hostChan(hostChan), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr(hostWr),
  .hostRd(hostRd), .hostRdData(hostRdData), .chanSig(chanSig), .rxLineTip(rxLineTip),
  .rxLineRing(rxLineRing), .userOutFirst(userOutFirst), .userOutSecond(userOutSecond),
  .rxRail(rxRail), .cmiLineEn(cmiLineEn));
`default_nettype wire

// ==== tb/uos_top_tb.sv ====
// Purpose: directed register-call tests of the user output select block
// Assumes: inputs change on the falling mclk edge
// Notes: routing sweep runs on channel 0 with the others left static
`timescale 1ns/10ps
`default_nettype none
module uos_top_tb import uos_pkg::*;;
  // ****************************************
  // bench
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] hostChan = 2'h0;
  logic [7:0] hostAddr = 8'h00;
  logic [7:0] hostWrData = 8'h00;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic [7:0] hostRdData;
  uos_chan_sig_t [3:0] chanSig = '0;
  logic [3:0] tbTip = 4'h0;
  logic [3:0] tbRing = 4'h0;
  logic usePart = 1'b0;
  logic send = 1'b0;
  logic grab = 1'b0;
  logic pTip, pRing, pBusy;
  logic [3:0] userOutFirst, userOutSecond, cmiLineEn;
  uos_rx_rail_t [3:0] rxRail;
  logic [7:0] rxByte = 8'h00;
  int n_fail = 0;
  int checks = 0;
  int nVal = 0;
  int cyc = 0;
  int lutA[16] = '{0, 16, 12, 11, 10, 9, 8, 7, 6, 15, 5, 3, 14, 13, 0, 1};
  int lutB[16] = '{0, 16, 12, 11, 10, 9, 8, 7, 6, 15, 5, 4, 14, 13, 0, 2};
  wire logic [3:0] tipIn = {tbTip[3:1], usePart ? pTip : tbTip[0]};
  wire logic [3:0] ringIn = {tbRing[3:1], usePart ? pRing : tbRing[0]};
  always #25 mclk = !mclk;
  uos_top dut (.mclk(mclk), .rst_n(rst_n), .hostChan(hostChan), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
    .chanSig(chanSig), .rxLineTip(tipIn), .rxLineRing(ringIn), .userOutFirst(userOutFirst),
    .userOutSecond(userOutSecond), .rxRail(rxRail), .cmiLineEn(cmiLineEn));
  uos_partner part (.mclk(mclk), .send(send), .txByte(8'ha5), .tip(pTip), .ring(pRing),
    .busy(pBusy));
  // registered outputs are taken at the falling edge, half a cycle after they settle
  always @(negedge mclk) begin
    cyc++;
    if (grab && rxRail[0].valid) begin
      rxByte <= {rxByte[6:0], rxRail[0].pos};
      nVal++;
    end
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    hostChan = ch;
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    @(negedge mclk);
    hostWr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    hostChan = ch;
    hostAddr = a;
    hostRd = 1'b1;
    @(negedge mclk);
    hostRd = 1'b0;
    chk8("read data", exp, hostRdData);
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(2'(c), ADDR_OUTPUT_A_CONTROL, CTRL_RESET);
      rd(2'(c), ADDR_OUTPUT_B_CONTROL, CTRL_RESET);
    end
    wr(2'h1, ADDR_OUTPUT_A_CONTROL, 8'h5c);
    wr(2'h2, ADDR_OUTPUT_B_CONTROL, 8'h9f);
    wr(2'h0, 8'h1c, 8'hff);
    rd(2'h1, ADDR_OUTPUT_A_CONTROL, 8'h5c);
    rd(2'h2, ADDR_OUTPUT_B_CONTROL, 8'h9f);
    rd(2'h0, 8'h1c, RD_UNMAPPED);
    rd(2'h0, ADDR_OUTPUT_A_CONTROL, CTRL_RESET);
    wr(2'h1, ADDR_OUTPUT_A_CONTROL, 8'h00);
    wr(2'h2, ADDR_OUTPUT_B_CONTROL, 8'h00);
    $display("test registers done");
    wr(2'h3, ADDR_OUTPUT_A_CONTROL, 8'h10);
    wr(2'h3, ADDR_OUTPUT_B_CONTROL, 8'h10);
    repeat (2) @(negedge mclk);
    chk8("static pins", 8'h88, {userOutFirst, userOutSecond});
    for (int k = 1; k < 32; k++) begin
      chanSig[0] = uos_chan_sig_t'((17'h1 << lutA[k%16]) | (17'h1 << lutB[k%16]));
      wr(2'h0, ADDR_OUTPUT_A_CONTROL, 8'(k));
      wr(2'h0, ADDR_OUTPUT_B_CONTROL, 8'(k));
      repeat (2) @(negedge mclk);
      chk8("routed pins", (k < 16) ? 8'h99 : (k == 16) ? 8'h99 : 8'h88,
        {userOutFirst, userOutSecond});
    end
    chanSig[0] = '0;
    chanSig[0].rxCrcErrorPulse = 1'b1;
    chanSig[0].rxLossSync = 1'b1;
    wr(2'h0, ADDR_OUTPUT_A_CONTROL, {4'h0, SEL_CRC_ERROR});
    repeat (2) @(negedge mclk);
    chk8("gated crc", 8'h08, {4'h0, userOutFirst});
    $display("test routing done");
    tbTip = 4'h1;
    wr(2'h0, ADDR_OUTPUT_A_CONTROL, 8'he0);
    repeat (3) @(negedge mclk);
    chk8("ttl cmi inverted", 8'h41, {rxRail[0].pos, rxRail[0].neg, 2'h0, cmiLineEn});
    wr(2'h0, ADDR_OUTPUT_A_CONTROL, 8'ha0);
    repeat (3) @(negedge mclk);
    chk8("ttl cmi plain", 8'h81, {rxRail[0].pos, rxRail[0].neg, 2'h0, cmiLineEn});
    wr(2'h0, ADDR_OUTPUT_A_CONTROL, 8'h40);
    repeat (3) @(negedge mclk);
    chk8("cmi invert gated", 8'h80, {rxRail[0].pos, rxRail[0].neg, 2'h0, cmiLineEn});
    $display("test front end done");
    wr(2'h0, ADDR_OUTPUT_A_CONTROL, 8'h00);
    wr(2'h0, ADDR_OUTPUT_B_CONTROL, 8'h80);
    usePart = 1'b1;
    repeat (3) @(negedge mclk);
    grab = 1'b1;
    send = 1'b1;
    @(negedge mclk);
    send = 1'b0;
    for (int w = 0; w < 60 && pBusy; w++) @(negedge mclk);
    repeat (3) @(negedge mclk);
    chk8("nrz byte", 8'ha5, rxByte);
    chk8("nrz pulses", 8'h08, 8'(nVal));
    $display("test nrz done");
    report_and_stop();
  end
endmodule // uos_top_tb
`default_nettype wire
